// ===== inc/erc_pkg.sv
// ==========================================
// timing and layout constants
package erc_pkg;
	localparam int unsigned ERC_CLK_HZ       = 40_000_000;
	localparam int unsigned ERC_LINK_HZ      = 8_000_000;
	localparam int unsigned ERC_SCL_HZ       = 100_000;
	localparam int unsigned ERC_I2C_QTR      = ERC_LINK_HZ / (ERC_SCL_HZ * 4);
	localparam int unsigned ERC_HEAD_TIME_S  = 10;
	localparam int unsigned ERC_HEAD_CYC     = ERC_HEAD_TIME_S * ERC_CLK_HZ;
	localparam int unsigned ERC_READ_TIME_MS = 1000;
	localparam int unsigned ERC_READ_CYC     = ERC_READ_TIME_MS * (ERC_CLK_HZ / 1000);
	localparam int unsigned ERC_WCYC_TIME_US = 5000;
	localparam int unsigned ERC_WCYC         = ERC_WCYC_TIME_US * (ERC_CLK_HZ / 1_000_000);
	localparam int unsigned ERC_BLINK_MS     = 250;
	localparam int unsigned ERC_BLINK_CYC    = ERC_BLINK_MS * (ERC_CLK_HZ / 1000);
	localparam int unsigned ERC_NUM_HEADS    = 1;
	localparam int unsigned ERC_NUM_EMU      = 4;
	// ==========================================
	// identification block layout
	localparam int unsigned ERC_EDID_LEN     = 128;
	localparam int unsigned ERC_EDID_AW      = 7;
	localparam int unsigned ERC_HDR_LEN      = 8;
	localparam logic [7:0]  ERC_HDR_EDGE     = 8'h00;
	localparam logic [7:0]  ERC_HDR_FILL     = 8'hff;
	localparam logic [7:0]  ERC_SUM_OK       = 8'h00;
	localparam logic [6:0]  ERC_EDID_DEV     = 7'h50;
	localparam int unsigned ERC_WR_LAST_STEP = 4;
	localparam int unsigned ERC_RD_LAST_STEP = 6;
	localparam int unsigned ERC_RD_RESTART   = 3;
	localparam int unsigned ERC_RD_RX_STEP   = 5;

	typedef enum logic [1:0] {K_START, K_TX, K_RX, K_STOP} erc_step_type;
	typedef enum logic [3:0] {
		S_START, S_READ, S_CHECK, S_OPEN, S_WRITE, S_GAP, S_HOLD, S_DONE, S_ISO
	} erc_state_type;
endpackage

// ===== hw/erc_i2c_link.sv
`timescale 1ns/10ps
module erc_i2c_link
	import erc_pkg::*;
#(
	parameter int unsigned QTR = ERC_I2C_QTR
) (
	input  wire logic       link_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       req_tgl_i,
	input  wire logic       op_rd_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       sda_i,
	output logic            ack_tgl_o,
	output logic [7:0]      rdata_o,
	output logic            nak_o,
	output logic            scl_oe_o,
	output logic            sda_oe_o
);
	localparam int CW = $clog2(QTR + 1);

	logic [2:0]   req_s_r;
	logic [2:0]   sda_s_r;
	logic         sda_f_r;
	logic         busy_r;
	logic         op_r;
	logic [7:0]   addr_r;
	logic [7:0]   data_r;
	logic [2:0]   step_r;
	logic [3:0]   bit_r;
	logic [1:0]   q_r;
	logic [CW-1:0] cnt_r;
	logic [7:0]   shf_r;
	erc_step_type kind;
	logic [7:0]   tx_byte;
	wire          new_req   = req_s_r[1] ^ req_s_r[2];
	wire          q_end     = cnt_r == CW'(QTR - 1);
	wire          is_byte   = kind == K_TX || kind == K_RX;
	wire          bit_end   = busy_r && q_end && q_r == 2'd3;
	wire          sample    = busy_r && is_byte && q_r == 2'd2 && cnt_r == '0;
	wire          last_step = step_r == 3'(op_r ? ERC_RD_LAST_STEP : ERC_WR_LAST_STEP);
	wire          step_end  = bit_end && (!is_byte || bit_r == 4'd8);
	wire          load      = busy_r && kind == K_TX && q_r == 2'd0 && cnt_r == '0 && bit_r == '0;

	// ==========================================
	// step decode
	assign kind = (step_r == '0 || (op_r && step_r == 3'(ERC_RD_RESTART))) ? K_START :
		last_step ? K_STOP : (op_r && step_r == 3'(ERC_RD_RX_STEP)) ? K_RX : K_TX;
	assign tx_byte = (step_r == 3'd1) ? {ERC_EDID_DEV, 1'b0} : (step_r == 3'd2) ? addr_r :
		op_r ? {ERC_EDID_DEV, 1'b1} : data_r;
	wire sda_low = (kind == K_START) ? q_r[1] : (kind == K_STOP) ? !q_r[1] :
		(kind == K_TX) ? (bit_r != 4'd8 && !shf_r[7]) : 1'b0;
	wire scl_low = (kind == K_START) ? q_r == 2'd3 : (kind == K_STOP) ? q_r == 2'd0 :
		(q_r == 2'd0 || q_r == 2'd3);

	// ==========================================
	// crossing and pin filter; data is held stable by the sender while a toggle is open
	always_ff @(posedge link_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			req_s_r <= '0;
			sda_s_r <= 3'h7;
			sda_f_r <= 1'b1;
		end else begin
			req_s_r <= {req_s_r[1:0], req_tgl_i};
			sda_s_r <= {sda_s_r[1:0], sda_i};
			if (sda_s_r[1] == sda_s_r[2]) begin
				sda_f_r <= sda_s_r[2];
			end
		end
	end

	always_ff @(posedge link_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_r <= 1'b0;
			op_r   <= 1'b0;
			addr_r <= 8'h00;
			data_r <= 8'h00;
			cnt_r  <= '0;
			q_r    <= '0;
			bit_r  <= '0;
			step_r <= '0;
		end else if (!busy_r) begin
			busy_r <= new_req;
			op_r   <= op_rd_i;
			addr_r <= addr_i;
			data_r <= wdata_i;
			cnt_r  <= '0;
			q_r    <= '0;
			bit_r  <= '0;
			step_r <= '0;
		end else begin
			cnt_r <= q_end ? '0 : cnt_r + 1'b1;
			if (q_end) begin
				q_r <= q_r + 1'b1;
			end
			if (bit_end) begin
				bit_r <= step_end ? '0 : bit_r + 1'b1;
			end
			if (step_end) begin
				step_r <= step_r + 1'b1;
				busy_r <= !last_step;
			end
		end
	end

	always_ff @(posedge link_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shf_r     <= 8'h00;
			nak_o     <= 1'b0;
			rdata_o   <= 8'h00;
			ack_tgl_o <= 1'b0;
			scl_oe_o  <= 1'b0;
			sda_oe_o  <= 1'b0;
		end else begin
			scl_oe_o <= busy_r && scl_low;
			sda_oe_o <= busy_r && sda_low;
			if (load) begin
				shf_r <= tx_byte;
			end else if (sample && bit_r != 4'd8 && kind == K_RX) begin
				shf_r <= {shf_r[6:0], sda_f_r};
			end else if (bit_end && kind == K_TX && bit_r != 4'd8) begin
				shf_r <= {shf_r[6:0], 1'b0};
			end
			if (!busy_r && new_req) begin
				nak_o <= 1'b0;
			end else if (sample && bit_r == 4'd8 && kind == K_TX && sda_f_r) begin
				nak_o <= 1'b1;
			end
			if (step_end && kind == K_RX) begin
				rdata_o <= shf_r;
			end
			if (step_end && last_step) begin
				ack_tgl_o <= ~ack_tgl_o;
			end
		end
	end
endmodule

// ===== hw/erc_edid_ctrl.sv
// Contract
// - read monitor data once at power-up, time-limited
// - skip emulator writes when data unchanged
// - flash port and blue LEDs until done
// - next head repeats, flashing its port LED
// - each head takes about ten seconds
// - read: monitor switch closed, mux isolated
// - open monitor switch before routing mux
// - advance mux until all emulators written
// - ignore display changes after sequence ends
// - emulators stay write-protected toward computers
// - invalid monitor data never reaches emulators
// - fault or tamper isolates all video
// - tamper isolates permanently, erases stored data
// - AUX always answered by internal simulator
`timescale 1ns/10ps
module erc_edid_ctrl
	import erc_pkg::*;
#(
	parameter int unsigned NUM_HEADS = ERC_NUM_HEADS,
	parameter int unsigned NUM_EMU   = ERC_NUM_EMU,
	parameter int unsigned HEAD_CYC  = ERC_HEAD_CYC,
	parameter int unsigned READ_CYC  = ERC_READ_CYC,
	parameter int unsigned WCYC      = ERC_WCYC,
	parameter int unsigned BLINK_CYC = ERC_BLINK_CYC,
	parameter int unsigned QTR       = ERC_I2C_QTR,
	localparam int EW = (NUM_HEADS * NUM_EMU > 1) ? $clog2(NUM_HEADS * NUM_EMU) : 1
) (
	input  wire logic                 CLOCK_I,
	input  wire logic                 ARST_N_I,
	input  wire logic                 LINK_CLK_I,
	input  wire logic                 SELFTEST_FAIL_I,
	input  wire logic                 TAMPER_I,
	input  wire logic                 SDA_I,
	output logic                      SCL_O,
	output logic                      SCL_OE_O,
	output logic                      SDA_O,
	output logic                      SDA_OE_O,
	output logic [NUM_HEADS-1:0]      MON_SW_O,
	output logic                      EMU_EN_O,
	output logic [EW-1:0]             EMU_SEL_O,
	output logic                      EMU_WP_O,
	output logic                      ISOLATE_O,
	output logic [NUM_HEADS-1:0]      PORT_LED_O,
	output logic                      BLUE_LED_O,
	output logic                      AUX_SIM_O
);
	localparam int HW = (NUM_HEADS > 1) ? $clog2(NUM_HEADS) : 1;
	localparam int MW = (NUM_EMU > 1) ? $clog2(NUM_EMU) : 1;
	localparam int AW = ERC_EDID_AW;

	erc_state_type    state_r;
	erc_state_type    state_nxt;
	logic [2:0]       pin_s_r [2];
	logic [1:0]       pin_f_r;
	logic             tamper_lat_r;
	logic [2:0]       ack_s_r;
	logic             req_tgl_r;
	logic             op_rd_r;
	logic [7:0]       addr_r;
	logic [7:0]       wdata_r;
	logic             pend_r;
	logic [AW-1:0]    idx_r;
	logic [AW-1:0]    idx_nxt;
	logic [MW-1:0]    emu_r;
	logic [HW-1:0]    head_r;
	logic [31:0]      tmr_r;
	logic [31:0]      head_tmr_r;
	logic [31:0]      blk_tmr_r;
	logic             blink_r;
	logic             fail_r;
	logic             differ_r;
	logic             hdr_ok_r;
	logic [7:0]       sum_r;
	logic [7:0]       fresh_r [ERC_EDID_LEN];
	logic [7:0]       held_r [NUM_HEADS][ERC_EDID_LEN];
	logic             link_ack;
	logic [7:0]       link_rdata;
	logic             link_nak;

	// ==========================================
	// decode
	wire tamper_f  = pin_f_r[1];
	wire fault_w   = pin_f_r[0] || pin_f_r[1] || tamper_lat_r;
	wire xdone     = ack_s_r[1] ^ ack_s_r[2];
	wire idx_last  = idx_r == AW'(ERC_EDID_LEN - 1);
	wire emu_last  = emu_r == MW'(NUM_EMU - 1);
	wire head_last = head_r == HW'(NUM_HEADS - 1);
	wire rd_over   = state_r == S_READ && tmr_r >= 32'(READ_CYC - 1);
	wire tmr_end   = tmr_r >= 32'(WCYC - 1);
	wire head_end  = head_tmr_r >= 32'(HEAD_CYC - 1);
	wire blk_end   = blk_tmr_r >= 32'(BLINK_CYC - 1);
	wire leave     = state_nxt != state_r;
	wire [7:0] held_byte = held_r[head_r][idx_r];
	wire [7:0] hdr_exp   = (idx_r == '0 || idx_r == AW'(ERC_HDR_LEN - 1)) ?
		ERC_HDR_EDGE : ERC_HDR_FILL;
	wire hdr_match = idx_r >= AW'(ERC_HDR_LEN) || link_rdata == hdr_exp;
	wire data_ok   = hdr_ok_r && sum_r == ERC_SUM_OK && !fail_r;
	wire do_copy   = state_r == S_CHECK && data_ok && differ_r;
	// a request leaves only once the path it needs is already switched at the pins
	wire sw_ready  = (state_r == S_READ) ? (MON_SW_O != '0) : EMU_EN_O;
	wire issue     = (state_r == S_READ || state_r == S_WRITE) && !pend_r && !xdone &&
		sw_ready && !fault_w;
	wire [NUM_HEADS-1:0] mon_sw_nxt = (state_r == S_READ && !fault_w) ?
		NUM_HEADS'(1) << head_r : '0;
	wire emu_en_nxt = (state_r == S_WRITE || state_r == S_GAP) && !fault_w;
	wire flash      = blink_r && state_r != S_DONE && state_r != S_ISO && !fault_w;
	wire [EW-1:0] emu_sel_nxt = EW'(int'(head_r) * NUM_EMU + int'(emu_r));

	// ==========================================
	// sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_START: begin
				state_nxt = S_READ;
			end
			S_READ: begin
				if (rd_over || (xdone && (link_nak || idx_last))) begin
					state_nxt = S_CHECK;
				end
			end
			S_CHECK: begin
				state_nxt = do_copy ? S_OPEN : S_HOLD;
			end
			S_OPEN: begin
				if (!pend_r) begin
					state_nxt = S_WRITE;
				end
			end
			S_WRITE: begin
				if (xdone) begin
					state_nxt = S_GAP;
				end
			end
			S_GAP: begin
				if (tmr_end) begin
					state_nxt = (idx_last && emu_last) ? S_HOLD : S_WRITE;
				end
			end
			S_HOLD: begin
				if (head_end && !pend_r) begin
					state_nxt = head_last ? S_DONE : S_READ;
				end
			end
			S_DONE: begin
				state_nxt = S_DONE;
			end
			S_ISO: begin
				state_nxt = S_ISO;
			end
			default: begin
				state_nxt = S_ISO;
			end
		endcase
		if (fault_w) begin
			state_nxt = S_ISO;
		end
	end

	assign idx_nxt = (leave && (state_nxt == S_READ || state_nxt == S_OPEN)) ? '0 :
		((state_r == S_READ && xdone) || (state_r == S_GAP && tmr_end)) ? idx_r + 1'b1 :
		idx_r;

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_r <= S_START;
			idx_r   <= '0;
		end else begin
			state_r <= state_nxt;
			idx_r   <= idx_nxt;
		end
	end

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			emu_r  <= '0;
			head_r <= '0;
		end else begin
			if (leave && state_nxt == S_OPEN) begin
				emu_r <= '0;
			end else if (state_r == S_GAP && tmr_end && idx_last && !emu_last) begin
				emu_r <= emu_r + 1'b1;
			end
			if (state_r == S_HOLD && state_nxt == S_READ) begin
				head_r <= head_r + 1'b1;
			end
		end
	end

	// ==========================================
	// timers
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			tmr_r      <= '0;
			head_tmr_r <= '0;
			blk_tmr_r  <= '0;
			blink_r    <= 1'b0;
		end else begin
			tmr_r      <= leave ? '0 : tmr_r + 1'b1;
			head_tmr_r <= (leave && state_nxt == S_READ) ? '0 :
				head_end ? head_tmr_r : head_tmr_r + 1'b1;
			blk_tmr_r  <= blk_end ? '0 : blk_tmr_r + 1'b1;
			blink_r    <= blk_end ? !blink_r : blink_r;
		end
	end

	// ==========================================
	// fault pins and link crossing
	for (genvar gp = 0; gp < 2; gp++) begin : g_pin
		wire pin_in = (gp == 0) ? SELFTEST_FAIL_I : TAMPER_I;
		always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
			if (!ARST_N_I) begin
				pin_s_r[gp] <= '0;
				pin_f_r[gp] <= 1'b0;
			end else begin
				pin_s_r[gp] <= {pin_s_r[gp][1:0], pin_in};
				if (pin_s_r[gp][1] == pin_s_r[gp][2]) begin
					pin_f_r[gp] <= pin_s_r[gp][2];
				end
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			tamper_lat_r <= 1'b0;
			ack_s_r      <= '0;
		end else begin
			tamper_lat_r <= tamper_lat_r || tamper_f;
			ack_s_r      <= {ack_s_r[1:0], link_ack};
		end
	end

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			req_tgl_r <= 1'b0;
			op_rd_r   <= 1'b0;
			addr_r    <= 8'h00;
			wdata_r   <= 8'h00;
			pend_r    <= 1'b0;
		end else begin
			pend_r <= issue || (pend_r && !xdone);
			if (issue) begin
				req_tgl_r <= ~req_tgl_r;
				op_rd_r   <= state_r == S_READ;
				addr_r    <= 8'(idx_r);
				wdata_r   <= held_byte;
			end
		end
	end

	// ==========================================
	// checks on the fresh copy
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			fail_r   <= 1'b0;
			differ_r <= 1'b0;
			hdr_ok_r <= 1'b1;
			sum_r    <= 8'h00;
		end else if (leave && state_nxt == S_READ) begin
			fail_r   <= 1'b0;
			differ_r <= 1'b0;
			hdr_ok_r <= 1'b1;
			sum_r    <= 8'h00;
		end else if (state_r == S_READ) begin
			fail_r <= fail_r || rd_over || (xdone && link_nak);
			if (xdone) begin
				differ_r <= differ_r || link_rdata != held_byte;
				hdr_ok_r <= hdr_ok_r && hdr_match;
				sum_r    <= sum_r + link_rdata;
			end
		end
	end

	// stored copies are volatile: after reset the first valid read always differs
	for (genvar gb = 0; gb < ERC_EDID_LEN; gb++) begin : g_byte
		always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
			if (!ARST_N_I) begin
				fresh_r[gb] <= 8'h00;
			end else if (tamper_lat_r) begin
				fresh_r[gb] <= 8'h00;
			end else if (state_r == S_READ && xdone && idx_r == AW'(gb)) begin
				fresh_r[gb] <= link_rdata;
			end
		end
		for (genvar gh = 0; gh < NUM_HEADS; gh++) begin : g_head
			always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					held_r[gh][gb] <= 8'h00;
				end else if (tamper_lat_r) begin
					held_r[gh][gb] <= 8'h00;
				end else if (do_copy && head_r == HW'(gh)) begin
					held_r[gh][gb] <= fresh_r[gb];
				end
			end
		end
	end

	// ==========================================
	// pins
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			MON_SW_O   <= '0;
			EMU_EN_O   <= 1'b0;
			EMU_SEL_O  <= '0;
			EMU_WP_O   <= 1'b1;
			ISOLATE_O  <= 1'b0;
			PORT_LED_O <= '0;
			BLUE_LED_O <= 1'b0;
			AUX_SIM_O  <= 1'b1;
			SCL_O      <= 1'b0;
			SDA_O      <= 1'b0;
		end else begin
			MON_SW_O   <= mon_sw_nxt;
			EMU_EN_O   <= emu_en_nxt;
			EMU_SEL_O  <= emu_sel_nxt;
			EMU_WP_O   <= !emu_en_nxt;
			ISOLATE_O  <= fault_w || state_r == S_ISO;
			PORT_LED_O <= flash ? NUM_HEADS'(1) << head_r : '0;
			BLUE_LED_O <= flash;
			AUX_SIM_O  <= 1'b1;
		end
	end

	erc_i2c_link #(
		.QTR(QTR)
	) u_link (
		.link_clk_i (LINK_CLK_I),
		.arst_n_i   (ARST_N_I),
		.req_tgl_i  (req_tgl_r),
		.op_rd_i    (op_rd_r),
		.addr_i     (addr_r),
		.wdata_i    (wdata_r),
		.sda_i      (SDA_I),
		.ack_tgl_o  (link_ack),
		.rdata_o    (link_rdata),
		.nak_o      (link_nak),
		.scl_oe_o   (SCL_OE_O),
		.sda_oe_o   (SDA_OE_O)
	);

	// ==========================================
	// checks
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!ARST_N_I);

	chk_read_window: assert property (state_r == S_READ |-> tmr_r < 32'(READ_CYC))
		else $error("read phase outlived its limit");
	chk_skip_same: assert property (state_r == S_CHECK && !differ_r |=> state_r != S_OPEN)
		else $error("write phase entered with identical data");
	chk_leds_done: assert property (state_r == S_DONE |=> !BLUE_LED_O && PORT_LED_O == '0)
		else $error("leds still flashing after completion");
	chk_port_led: assert property (PORT_LED_O != '0 |-> BLUE_LED_O &&
		PORT_LED_O == NUM_HEADS'(1) << $past(head_r))
		else $error("wrong port led for current head");
	chk_head_time: assert property (state_r == S_HOLD && state_nxt == S_READ |->
		head_tmr_r >= 32'(HEAD_CYC - 1))
		else $error("next head started too early");
	chk_read_iso: assert property (MON_SW_O != '0 |-> !EMU_EN_O)
		else $error("emulator reachable while monitor switch closed");
	chk_switch_order: assert property ($rose(EMU_EN_O) |-> $past(MON_SW_O) == '0)
		else $error("mux routed before monitor switch opened");
	chk_mux_step: assert property (state_r == S_GAP && tmr_end && idx_last &&
		!emu_last && !fault_w |=> emu_r == $past(emu_r) + 1'b1 ##1
		EMU_SEL_O == $past(emu_sel_nxt))
		else $error("mux did not advance to next emulator");
	chk_done_stay: assert property (state_r == S_DONE |=> state_r inside {S_DONE, S_ISO})
		else $error("sequence restarted after completion");
	chk_wp_hold: assert property (!EMU_WP_O |-> EMU_EN_O && !ISOLATE_O)
		else $error("emulator writable outside write phase");
	chk_bad_data: assert property (state_r == S_CHECK && !data_ok |-> !do_copy
		##1 state_r != S_OPEN)
		else $error("invalid data propagated");
	chk_iso_fault: assert property (fault_w |=> ISOLATE_O && !EMU_EN_O && MON_SW_O == '0)
		else $error("fault did not isolate video");
	chk_tamper_erase: assert property (tamper_lat_r |=> ISOLATE_O &&
		held_r[0][0] == 8'h00 && fresh_r[ERC_EDID_LEN-1] == 8'h00)
		else $error("tamper did not erase stored data");
	chk_diff_seen: assert property (state_r == S_READ && xdone &&
		link_rdata != held_byte |=> differ_r)
		else $error("byte mismatch not recorded");
endmodule

// ===== tb/erc_i2c_partner.sv
`timescale 1ns/10ps
// ==========================================
// behavioural monitor eeprom and emulator target
module erc_i2c_partner (
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic mon_on_i,
	input  wire logic emu_on_i,
	input  wire logic nak_i,
	output logic      pull_o
);
	logic [7:0] mem [128];
	logic [7:0] sh, tx, ptr, wr_addr, wr_data;
	logic       on, ok, tx_go, txing;
	int         nb, ph;
	event       wr_ev, rd_ev;

	initial begin
		pull_o = 1'b0;
		on = 1'b0;
		ptr = 8'h00;
	end
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		on = 1'b1;
		nb = -1;
		ph = 0;
		txing = 1'b0;
		tx_go = 1'b0;
		pull_o = 1'b0;
	end
	always @(posedge sda_i) if (scl_i === 1'b1) on = 1'b0;
	always @(posedge scl_i) if (on && !txing && nb < 8) sh = {sh[6:0], sda_i};
	// unselected target never acks; the mux position is not seen here, so a stray one shows only in the emulator byte check
	task automatic byte_in();
		if (ph == 0) ok = (sh[7:1] == 7'h50) && (mon_on_i || emu_on_i) && !(nak_i && mon_on_i);
		if (ph == 0 && sh[0]) tx_go = ok;
		if (ph == 0 && sh[0]) tx = mem[ptr[6:0]];
		if (ph == 1) ptr = sh;
		if (ph == 2 && emu_on_i) begin
			wr_addr = ptr;
			wr_data = sh;
			-> wr_ev;
		end
		if (ph == 2) ptr = ptr + 8'h01;
		pull_o = ok;
		ph = ph + 1;
	endtask
	always @(negedge scl_i) if (on) begin
		nb = nb + 1;
		pull_o = 1'b0;
		if (nb == 9) begin
			nb = 0;
			txing = tx_go;
			tx_go = 1'b0;
		end else if (nb == 8 && txing) begin
			txing = 1'b0;
			-> rd_ev;
		end else if (nb == 8) begin
			byte_in();
		end
		if (txing && nb < 8) pull_o = ~tx[7 - nb];
	end
endmodule

// ===== tb/erc_edid_ctrl_test.sv
`timescale 1ns/10ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module erc_edid_ctrl_test;
	import erc_pkg::*;
	// one head: 128 reads and 256 writes at two link cycles per quarter
	localparam int unsigned HEAD  = 640000;
	localparam int unsigned LIMIT = 760000;
	logic       clk, link_clk, arst_n, st_fail, tamper, nak, pull;
	logic       scl_o, scl_oe, sda_o, sda_oe, emu_en, emu_wp, iso, blue, aux, blue_q;
	logic [0:0] mon_sw, port_led, emu_sel;
	logic [7:0] sum, b;
	logic [23:0] exp_q [$];
	int         error_cnt, comparisons, cyc, t0, toggles, led_diff, mark;
	wire        scl = scl_oe ? 1'b0 : 1'b1;
	wire        sda = (sda_oe || pull) ? 1'b0 : 1'b1;

	// sda filter lags about five link cycles: one-cycle quarters would sample stale bits
	erc_edid_ctrl #(.NUM_HEADS(1), .NUM_EMU(2), .HEAD_CYC(HEAD), .READ_CYC(260000),
		.WCYC(50), .BLINK_CYC(16), .QTR(2)) erc_edid_ctrl_inst (
		.CLOCK_I(clk), .ARST_N_I(arst_n), .LINK_CLK_I(link_clk), .SELFTEST_FAIL_I(st_fail),
		.TAMPER_I(tamper), .SDA_I(sda), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_O(sda_o),
		.SDA_OE_O(sda_oe), .MON_SW_O(mon_sw), .EMU_EN_O(emu_en), .EMU_SEL_O(emu_sel),
		.EMU_WP_O(emu_wp), .ISOLATE_O(iso), .PORT_LED_O(port_led), .BLUE_LED_O(blue),
		.AUX_SIM_O(aux));
	erc_i2c_partner erc_i2c_partner_inst (.scl_i(scl), .sda_i(sda), .mon_on_i(mon_sw[0]),
		.emu_on_i(emu_en), .nak_i(nak), .pull_o(pull));

	// ==========================================
	// clocks, cycle count, led watch, hang guard
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #62.5 link_clk = ~link_clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (arst_n && blue !== blue_q) toggles++;
		if (arst_n && blue !== port_led[0]) led_diff++;
		blue_q = blue;
		if (cyc == LIMIT) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t run did not finish", $time);
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons=%0d errors=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic do_reset();
		arst_n = 1'b0;
		repeat (6) @(posedge clk);
		#2 arst_n = 1'b1;
		t0 = cyc;
	endtask
	task automatic wait_rel(input int n);
		while (cyc - t0 < n) @(posedge clk);
		#2;
	endtask
	// random body, valid header and zero byte sum; note = expect it on every emulator
	task automatic fill_edid(input logic note);
		sum = 8'h00;
		for (int i = 0; i < ERC_EDID_LEN; i++) begin
			b = (i == 0 || i == 7) ? ERC_HDR_EDGE : (i < ERC_HDR_LEN) ? ERC_HDR_FILL : 8'($urandom());
			if (i == ERC_EDID_LEN - 1) b = ERC_SUM_OK - sum;
			sum = sum + b;
			erc_i2c_partner_inst.mem[i] = b;
		end
		if (note) for (int e = 0; e < 2; e++) for (int i = 0; i < ERC_EDID_LEN; i++)
			exp_q.push_back({8'(e), 8'(i), erc_i2c_partner_inst.mem[i]});
	endtask

	// ==========================================
	// result watchers
	initial forever begin
		@(erc_i2c_partner_inst.wr_ev);
		`CHK(exp_q.size() > 0, 1'b1, "emulator write not expected")
		if (exp_q.size() > 0) `CHK({7'h00, emu_sel, erc_i2c_partner_inst.wr_addr, erc_i2c_partner_inst.wr_data}, exp_q.pop_front(), "emulator byte")
		`CHK({mon_sw, emu_wp}, 2'b00, "monitor switch or protect during write")
	end
	initial forever begin
		@(erc_i2c_partner_inst.rd_ev);
		`CHK({mon_sw, emu_en, emu_wp}, 3'b101, "read path setup")
	end

	// ==========================================
	// main sequence
	initial begin
		{st_fail, tamper, nak, arst_n, blue_q} = 5'b00000;
		{error_cnt, comparisons, cyc, t0, toggles, led_diff} = '0;
		void'($urandom(32'h69c1));
		fill_edid(1'b1);
		do_reset();
		wait_rel(20);
		`CHK({aux, iso, scl_o, sda_o}, 4'b1000, "aux, isolation or fixed pin level")
		wait (exp_q.size() == 0);
		wait_rel(HEAD - 40);
		mark = toggles;
		wait_rel(HEAD - 4);
		`CHK(toggles > mark, 1'b1, "flashing stopped early")
		wait_rel(HEAD + 100);
		mark = toggles;
		// display swapped after the sequence: must be left alone
		for (int i = 0; i < ERC_EDID_LEN; i++) erc_i2c_partner_inst.mem[i] = ~erc_i2c_partner_inst.mem[i];
		wait_rel(HEAD + 3000);
		`CHK({toggles == mark, blue, port_led, mon_sw, emu_en}, 5'b10000, "not idle when done")
		`CHK(led_diff, 0, "port and blue leds differ")
		nak = 1'b1;
		do_reset();
		mark = toggles;
		wait_rel(30000);
		`CHK({emu_en, emu_wp, toggles > mark}, 3'b011, "refused block handling")
		// one-cycle random glitch on the fault pins must die in the filter
		{tamper, st_fail} = 2'($urandom_range(3, 1));
		wait_rel(30001);
		{tamper, st_fail} = 2'b00;
		wait_rel(30006);
		`CHK(iso, 1'b0, "pin glitch not filtered")
		tamper = 1'b1;
		wait_rel(30014);
		`CHK({iso, emu_en, mon_sw, blue, port_led}, 5'b10000, "tamper isolation")
		tamper = 1'b0;
		wait_rel(30200);
		`CHK({iso, emu_en, mon_sw}, 3'b100, "isolation not held")
		nak = 1'b0;
		fill_edid(1'b0);
		do_reset();
		wait_rel(5000);
		st_fail = 1'b1;
		wait_rel(5008);
		`CHK({iso, emu_en, mon_sw, blue}, 4'b1000, "self test isolation")
		wait_rel(40000);
		`CHK({iso, emu_en, emu_wp}, 3'b101, "isolation held after fault")
		report_and_stop();
	end
endmodule
